// *** hdl/occ_pkg.sv ***
// package for the output channel configuration bank
// assumes a byte-wide register port and eight channels A..H
package occ_pkg;
	localparam int NUM_CH        = 8;
	localparam int ADDR_W        = 8;
	localparam int DATA_W        = 8;
	localparam int DLY_W         = 9;
	// register layout: two bytes per channel
	localparam logic [7:0] CH_BASE   = 8'h00;
	localparam int         CH_STRIDE = 2;
	localparam logic [7:0] STAT_ADDR = 8'h10;
	localparam logic [7:0] EXT_ADDR  = 8'h11;
	// second byte fields
	localparam int B_PD    = 7;
	localparam int B_LOSUP = 6;
	localparam int B_RET   = 5;
	localparam int B_IDLE  = 3;
	localparam int B_QUIET = 2;
	localparam int B_CS    = 1;
	localparam int B_DLY0  = 0;
	// external source byte: bit 0 channel C, bit 1 channel D
	localparam int CH_C = 2;
	localparam int CH_D = 3;
	// reset values
	localparam logic [8:0] DLY_RST   = 9'h000;
	localparam logic       PD_RST    = 1'h0;
	localparam logic       LOSUP_RST = 1'h0;
	localparam logic       RET_RST   = 1'h0;
	localparam logic       CS_RST    = 1'h0;
	localparam logic       IDLE_RST  = 1'h1;
	localparam logic       QUIET_RST = 1'h0;
	localparam logic       EXT_RST   = 1'h0;
	localparam int DLY_STEP_PS = 127;
	localparam logic [7:0] ZERO8 = 8'h00;

	typedef enum logic [1:0] {
		OCC_OUT_OFF   = 2'b00,
		OCC_OUT_CLOCK = 2'b01,
		OCC_OUT_SYNC  = 2'b10,
		OCC_OUT_EXT   = 2'b11
	} occ_mode_e;

	typedef struct packed {
		logic [8:0] dly;
		logic       pd;
		logic       losup;
		logic       retime;
		logic       cs_sel;
		logic       idle_kind;
		logic       quiet;
		logic       ext_sel;
	} occ_cfg_s;

	typedef struct packed {
		occ_mode_e  mode;
		logic [8:0] dly;
		logic       run;
		logic       sync_toggle;
		logic       idle_cross;
	} occ_ctl_s;
endpackage

// *** hdl/occ_chan_ctl.sv ***
// per-channel control decode from stored configuration
// assumes the configuration is registered upstream
`timescale 1ns/10ps
`default_nettype none
module occ_chan_ctl #(
	parameter bit HAS_EXT  = 1'b0,
	parameter bit HAS_SYNC = 1'b1
) (
	input  wire occ_pkg::occ_cfg_s cfg, // stored fields
	output var  occ_pkg::occ_ctl_s ctl  // decoded control
);
	wire ext_on  = HAS_EXT && cfg.ext_sel;
	wire sync_on = cfg.cs_sel;
	// channel power-down wins over the run, mode and delay selects below it
	assign ctl.run  = !cfg.pd;
	assign ctl.mode = cfg.pd ? occ_pkg::OCC_OUT_OFF :
		ext_on ? occ_pkg::OCC_OUT_EXT :
		sync_on ? occ_pkg::OCC_OUT_SYNC :
		occ_pkg::OCC_OUT_CLOCK;
	// delay bypassed with divider when buffering the external input
	assign ctl.dly = (cfg.pd || ext_on) ? occ_pkg::DLY_RST : cfg.dly;
	// lvpecl-only channels have no idle-level or quiet controls
	assign ctl.sync_toggle = HAS_SYNC ? !cfg.quiet : 1'b1;
	assign ctl.idle_cross  = HAS_SYNC ? cfg.idle_kind : 1'b0;
endmodule
`default_nettype wire

// *** hdl/occ_bank.sv ***
// output channel configuration bank, eight channels
// assumes a synchronous byte register port, one clock
`timescale 1ns/10ps
`default_nettype none
module occ_bank #(
	parameter int NCH = occ_pkg::NUM_CH
) (
	input  wire logic                     CLK,       // 125 MHz clock
	input  wire logic                     RSTN,      // async reset, low
	input  wire logic                     CE,        // clock enable
	input  wire logic [occ_pkg::ADDR_W-1:0] ADDR,    // register address
	input  wire logic [occ_pkg::DATA_W-1:0] WDATA,   // write data
	input  wire logic                     WR,        // write strobe
	input  wire logic                     RD,        // read strobe
	output logic [occ_pkg::DATA_W-1:0]    RDATA,     // read data
	output logic [NCH-1:0]                CH_RUN,    // channel running
	output logic [2*NCH-1:0]              CH_MODE,   // occ_mode_e per ch
	output logic [9*NCH-1:0]              CH_DLY,    // delay code per ch
	output logic [NCH-1:0]                SYNC_TOG,  // sync pulses toggle
	output logic [NCH-1:0]                IDLE_CROSS,// idle at cross point
	output logic [NCH-1:0]                LOSUP,     // low-supply amplitude
	output logic [NCH-1:0]                RETIME     // divider retime
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	occ_pkg::occ_cfg_s cfg_q [NCH];
	occ_pkg::occ_ctl_s ctl   [NCH];
	logic [occ_pkg::DATA_W-1:0] rdata_d;

	wire [7:0] rel   = ADDR - occ_pkg::CH_BASE;
	wire       in_ch = ADDR < (occ_pkg::CH_BASE + 8'(occ_pkg::CH_STRIDE * NCH));
	wire [6:0] ch_ix = rel[7:1];
	wire       hi_b  = rel[0];
	wire       wr_ext = WR && (ADDR == occ_pkg::EXT_ADDR);

	// ------------------------------------------------------------
	// per channel registers and decode
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gch
			wire sel   = in_ch && (ch_ix == 7'(g));
			wire wr_lo = WR && sel && !hi_b;
			wire wr_hi = WR && sel && hi_b;
			localparam bit IS_CD = (g == occ_pkg::CH_C) || (g == occ_pkg::CH_D);
			localparam int EXT_BIT = (g == occ_pkg::CH_D) ? 1 : 0;
			always_ff @(posedge CLK or negedge RSTN) begin
				if (!RSTN) begin
					cfg_q[g].dly       <= occ_pkg::DLY_RST;
					cfg_q[g].pd        <= occ_pkg::PD_RST;
					cfg_q[g].losup     <= occ_pkg::LOSUP_RST;
					cfg_q[g].retime    <= occ_pkg::RET_RST;
					cfg_q[g].cs_sel    <= occ_pkg::CS_RST;
					cfg_q[g].idle_kind <= occ_pkg::IDLE_RST;
					cfg_q[g].quiet     <= occ_pkg::QUIET_RST;
					cfg_q[g].ext_sel   <= occ_pkg::EXT_RST;
				end else if (CE) begin
					if (wr_lo)
						cfg_q[g].dly[8:1] <= WDATA;
					if (wr_hi) begin
						cfg_q[g].dly[0]    <= WDATA[occ_pkg::B_DLY0];
						cfg_q[g].pd        <= WDATA[occ_pkg::B_PD];
						cfg_q[g].losup     <= WDATA[occ_pkg::B_LOSUP];
						cfg_q[g].retime    <= WDATA[occ_pkg::B_RET];
						cfg_q[g].cs_sel    <= WDATA[occ_pkg::B_CS];
						// idle/quiet bits absent on the lvpecl-only pair
						if (!IS_CD) begin
							cfg_q[g].idle_kind <= WDATA[occ_pkg::B_IDLE];
							cfg_q[g].quiet     <= WDATA[occ_pkg::B_QUIET];
						end
					end
					if (wr_ext && IS_CD)
						cfg_q[g].ext_sel <= WDATA[EXT_BIT];
				end
			end
			occ_chan_ctl #(
				.HAS_EXT  (IS_CD),
				.HAS_SYNC (!IS_CD)
			) u_ctl (
				.cfg (cfg_q[g]),
				.ctl (ctl[g])
			);
			always_ff @(posedge CLK or negedge RSTN) begin
				if (!RSTN) begin
					CH_RUN[g]          <= 1'b1;
					CH_MODE[2*g +: 2]  <= occ_pkg::OCC_OUT_CLOCK;
					CH_DLY[9*g +: 9]   <= occ_pkg::DLY_RST;
					SYNC_TOG[g]        <= 1'b1;
					IDLE_CROSS[g]      <= !IS_CD;
					LOSUP[g]           <= occ_pkg::LOSUP_RST;
					RETIME[g]          <= occ_pkg::RET_RST;
				end else if (CE) begin
					CH_RUN[g]          <= ctl[g].run;
					CH_MODE[2*g +: 2]  <= ctl[g].mode;
					CH_DLY[9*g +: 9]   <= ctl[g].dly;
					SYNC_TOG[g]        <= ctl[g].sync_toggle;
					IDLE_CROSS[g]      <= ctl[g].idle_cross;
					LOSUP[g]           <= cfg_q[g].losup;
					RETIME[g]          <= cfg_q[g].retime;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// read back
	// ------------------------------------------------------------
	occ_pkg::occ_cfg_s rc;
	assign rc = cfg_q[ch_ix[2:0]];
	wire [7:0] hi_word = {rc.pd, rc.losup, rc.retime, 1'b0,
		rc.idle_kind, rc.quiet, rc.cs_sel, rc.dly[0]};
	wire [7:0] ext_word = {6'h00, cfg_q[occ_pkg::CH_D].ext_sel,
		cfg_q[occ_pkg::CH_C].ext_sel};
	wire [7:0] stat_word = 8'(~CH_RUN);
	always_comb begin
		if (in_ch)
			rdata_d = hi_b ? hi_word : rc.dly[8:1];
		else if (ADDR == occ_pkg::EXT_ADDR)
			rdata_d = ext_word;
		else if (ADDR == occ_pkg::STAT_ADDR)
			rdata_d = stat_word;
		else
			rdata_d = occ_pkg::ZERO8;
	end
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			RDATA <= occ_pkg::ZERO8;
		else if (CE)
			RDATA <= RD ? rdata_d : occ_pkg::ZERO8;
	end
endmodule
`default_nettype wire

// *** test/occ_bank_sva.sv ***
// port assertions for the channel configuration bank
// assumes it is bound onto occ_bank with CE held high
`timescale 1ns/10ps
`default_nettype none
module occ_bank_sva (
	input wire logic        CLK,       // clock
	input wire logic        RSTN,      // reset, low
	input wire logic        WR,        // write strobe
	input wire logic        RD,        // read strobe
	input wire logic [7:0]  RDATA,     // read data
	input wire logic [7:0]  CH_RUN,    // running
	input wire logic [15:0] CH_MODE,   // modes
	input wire logic [71:0] CH_DLY,    // delays
	input wire logic [7:0]  SYNC_TOG,  // toggle
	input wire logic [7:0]  IDLE_CROSS // idle level
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data without a read");
	a_run_mode: assert property (CH_RUN[0] == (CH_MODE[1:0] != 2'h0))
		else $error("run and mode disagree");
	a_off_delay: assert property (!CH_RUN[0] |-> CH_DLY[8:0] == 9'h000)
		else $error("delay kept while off");
	a_ext_only_cd: assert property (CH_MODE[1:0] != 2'h3)
		else $error("external mode on channel A");
	a_ext_delay: assert property (CH_MODE[7:6] == 2'h3 |-> CH_DLY[35:27] == 9'h000)
		else $error("delay kept while buffering");
	a_cd_idle: assert property (IDLE_CROSS[3:2] == 2'h0)
		else $error("idle level on channels C D");
	a_cd_toggle: assert property (SYNC_TOG[3:2] == 2'h3)
		else $error("quiet on channels C D");
	a_out_cause: assert property ($changed({CH_MODE, CH_DLY}) |-> $past(WR, 2))
		else $error("output moved without a write");
endmodule
bind occ_bank occ_bank_sva chk (.CLK(CLK), .RSTN(RSTN), .WR(WR), .RD(RD),
	.RDATA(RDATA), .CH_RUN(CH_RUN), .CH_MODE(CH_MODE), .CH_DLY(CH_DLY),
	.SYNC_TOG(SYNC_TOG), .IDLE_CROSS(IDLE_CROSS));
`default_nettype wire

// *** test/occ_conv_model.sv ***
// converter side: notes which channels feed sync pulses
// assumes the mode bus of occ_bank
`timescale 1ns/10ps
`default_nettype none
module occ_conv_model (
	input wire logic        clk,   // clock
	input wire logic [15:0] mode,  // channel modes
	output var logic [7:0]  sync_q // sync channels
);
	always_ff @(posedge clk) begin
		for (int i = 0; i < 8; i++) sync_q[i] <= mode[2*i+:2] == 2'h2;
	end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the channel configuration bank
// assumes the occ_pkg register map; CE held high
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,s) begin checks++; if ((s) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_top;
	logic        clk = 0, rstn = 0, wr = 0, rd = 0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, run, tog, idle, los, ret, syn;
	logic [15:0] mode;
	logic [71:0] dly;
	int          fails = 0, checks = 0, cyc = 0;
	always #4 clk = ~clk; // far below the delay input ceiling
	occ_bank uut (.CLK(clk), .RSTN(rstn), .CE(1'h1), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .CH_RUN(run), .CH_MODE(mode),
		.CH_DLY(dly), .SYNC_TOG(tog), .IDLE_CROSS(idle), .LOSUP(los),
		.RETIME(ret));
	occ_conv_model conv (.clk(clk), .mode(mode), .sync_q(syn));
	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge clk);
		wr <= 1'h1; addr <= a; wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rd_reg(input logic [7:0] a, e);
		@(posedge clk);
		rd <= 1'h1; addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 `CHK("rdata", e, rdata)
	endtask
	task automatic wrap_up;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			wrap_up;
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'h1;
		for (int n = 0; n < 8; n++) begin
			rd_reg(8'(2*n), 8'h00);
			rd_reg(8'(2*n+1), 8'h08);
		end
		`CHK("rst out", {8'hF3, 8'hFF, 16'h5555}, {idle, run, mode})
		$display("test reset done");
		// even channels sync with flags set, odd clock with quiet set
		for (int n = 0; n < 8; n++) begin
			wr_reg(8'(2*n), 8'(n+16));
			wr_reg(8'(2*n+1), n[0] ? 8'h04 : 8'h63);
		end
		for (int n = 0; n < 8; n++) begin
			rd_reg(8'(2*n), 8'(n+16));
			rd_reg(8'(2*n+1), (n/2 == 1) ? (n[0] ? 8'h08 : 8'h6B) : (n[0] ? 8'h04 : 8'h63));
			`CHK("dly", {8'(n+16), ~n[0]}, dly[9*n+:9])
			`CHK("mode", n[0] ? 2'h1 : 2'h2, mode[2*n+:2])
			`CHK("tog", 1'(!n[0] || n/2 == 1), tog[n])
			`CHK("idle", 1'h0, idle[n])
			`CHK("flags", {3{~n[0]}}, {los[n], ret[n], syn[n]})
		end
		$display("test channels done");
		wr_reg(8'h01, 8'hE3);
		repeat (2) @(posedge clk);
		#1 `CHK("pd", 12'h000, {run[0], mode[1:0], dly[8:0]})
		rd_reg(8'h10, 8'h01);
		wr_reg(8'h11, 8'h03);
		rd_reg(8'h11, 8'h03);
		`CHK("ext", 22'h3C0000, {mode[7:4], dly[35:18]})
		wr_reg(8'h20, 8'hFF);
		rd_reg(8'h20, 8'h00);
		rd_reg(8'h00, 8'h10);
		$display("test power and source done");
		wrap_up;
	end
endmodule
`default_nettype wire
